// ==== hw/dch_device.sv ====
// Peripheral controller end: raises breaks on behalf of its user logic.
`timescale 1ns/100ps
module dch_device
    import dch_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic resetn,
    // I/O bus side.
    dch_if.device io,
    // User side.
    input wire logic start,
    input wire brk_kind_t kind,
    input wire logic inhibit_increment,
    input wire logic [ADDR_W-1:0] address,
    input wire logic [WORD_W-1:0] wdata,
    output logic [WORD_W-1:0] rdata,
    output logic rdata_valid,
    output logic pending,
    output logic stopped
);
    import dch_pkg::*;

    logic req_r, req_nxt;
    brk_kind_t kind_r, kind_nxt;
    logic inh_r, inh_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [WORD_W-1:0] wd_r, wd_nxt, rd_r, rd_nxt;
    logic rv_r, rv_nxt;
    logic stop_r, stop_nxt;

    assign io.channel_break_request = req_r;
    assign io.read_request_line = req_r && (kind_r == BRK_MC_OUT || kind_r == BRK_ADD_MEM);
    assign io.write_request_line = req_r && (kind_r == BRK_MC_IN || kind_r == BRK_ADD_MEM);
    assign io.increment_memory_line = req_r && kind_r == BRK_INC_MEM;
    assign io.inhibit_increment_line = req_r && inh_r;
    assign io.io_address = addr_r;
    assign io.io_data_to_engine = wd_r;
    assign rdata = rd_r;
    assign rdata_valid = rv_r;
    assign pending = req_r;
    assign stopped = stop_r;

    always_comb begin
        req_nxt = req_r;
        kind_nxt = kind_r;
        inh_nxt = inh_r;
        addr_nxt = addr_r;
        wd_nxt = wd_r;
        rd_nxt = rd_r;
        rv_nxt = 1'b0;
        stop_nxt = stop_r || io.count_overflow_signal;
        // After overflow no further break is asked for.
        if (start && !req_r && !stop_nxt) begin
            req_nxt = 1'b1;
            kind_nxt = kind;
            inh_nxt = inhibit_increment;
            addr_nxt = address;
            wd_nxt = wdata;
        end
        if (io.device_output_pulse) begin
            rd_nxt = io.io_data_to_device;
            rv_nxt = 1'b1;
        end
        if (io.break_done) begin
            req_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            req_r <= 1'b0;
            kind_r <= BRK_SC_OUT;
            inh_r <= 1'b0;
            addr_r <= ADDR_ZERO;
            wd_r <= WORD_ZERO;
            rd_r <= WORD_ZERO;
            rv_r <= 1'b0;
            stop_r <= 1'b0;
        end else begin
            req_r <= req_nxt;
            kind_r <= kind_nxt;
            inh_r <= inh_nxt;
            addr_r <= addr_nxt;
            wd_r <= wd_nxt;
            rd_r <= rd_nxt;
            rv_r <= rv_nxt;
            stop_r <= stop_nxt;
        end
    end
endmodule // dch_device

// ==== hw/dch_engine.sv ====
// Data channel break engine: serves peripheral breaks against core memory.
// Summary of operation
// - Single output: device address in, memory word out.
// - Address to data register, read, drive, output pulse.
// - Multicycle input: three processor and memory cycles.
// - Word count read/pause/write, plus one, rewrite.
// - Address plus one; increment current address; keep it.
// - Capture input data with input pulse at word count write.
// - Write buffer to memory on acknowledge, end.
// - Count carry raises overflow; finish current break.
// - Device stops requesting after overflow.
// - Multicycle output: read, stall, drive, output pulse.
// - Add to memory: sum, rewrite, drive, pulse.
// - Both request lines together select add to memory.
// - Increment memory line: word count cycle only.
// - Inhibit line keeps current address unchanged.
// - Back-to-back output requests handled like input.
// - Single output latency within worst case bound.
`timescale 1ns/100ps
module dch_engine
    import dch_pkg::*;
#(
    parameter int FDEPTH = FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic resetn,
    // Peripheral side.
    dch_if.engine io,
    // Memory side.
    output logic mem_req,
    output logic mem_write,
    output logic mem_rpw,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [WORD_W-1:0] mem_wdata,
    input wire logic mem_addr_ack,
    input wire logic mem_rd_restart,
    input wire logic [WORD_W-1:0] mem_rdata,
    // Status.
    output logic busy,
    output logic latency_over
);
    import dch_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_WC_RD = 4'h1,
        S_WC_WR = 4'h2,
        S_CA_RD = 4'h3,
        S_CA_WR = 4'h4,
        S_DT_REQ = 4'h5,
        S_DT_RD = 4'h6,
        S_DT_WR = 4'h7,
        S_PULSE = 4'h8
    } eng_state_t;

    eng_state_t st_r, st_nxt;
    brk_kind_t kind_r, kind_nxt;
    logic [WORD_W-1:0] dsr_r, dsr_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic inh_r, inh_nxt;
    logic ovf_r, ovf_nxt;
    logic opulse_r, opulse_nxt;
    logic ipulse_r, ipulse_nxt;
    logic done_r, done_nxt;
    logic wait_low_r, wait_low_nxt;
    logic [WORD_W-1:0] dout_r, dout_nxt;
    logic [15:0] lat_r, lat_nxt;
    logic late_r, late_nxt;
    logic [WORD_W:0] sum;
    // Pins from the peripheral are synchronised before any decision.
    logic req_s1_r, req_s2_r, rd_s1_r, rd_s2_r, wr_s1_r, wr_s2_r;
    logic inc_s1_r, inc_s2_r, inh_s1_r, inh_s2_r;
    logic [ADDR_W-1:0] adr_s1_r, adr_s2_r;
    logic [WORD_W-1:0] dat_s1_r, dat_s2_r;
    // Input words pass through the FIFO; the engine drains it in the write cycle.
    logic fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [WORD_W-1:0] fifo_out_data;

    word_fifo #(.WIDTH(WORD_W), .DEPTH(FDEPTH)) u_fifo (
        .mclk(mclk),
        .resetn(resetn),
        .in_valid(ipulse_r),
        .in_ready(fifo_in_ready),
        .in_data(dat_s2_r),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            {req_s1_r, req_s2_r, rd_s1_r, rd_s2_r, wr_s1_r, wr_s2_r} <= '0;
            {inc_s1_r, inc_s2_r, inh_s1_r, inh_s2_r} <= '0;
            adr_s1_r <= ADDR_ZERO;
            adr_s2_r <= ADDR_ZERO;
            dat_s1_r <= WORD_ZERO;
            dat_s2_r <= WORD_ZERO;
        end else begin
            {req_s1_r, rd_s1_r, wr_s1_r} <= {io.channel_break_request,
                io.read_request_line, io.write_request_line};
            {inc_s1_r, inh_s1_r} <= {io.increment_memory_line, io.inhibit_increment_line};
            {req_s2_r, rd_s2_r, wr_s2_r, inc_s2_r, inh_s2_r} <=
                {req_s1_r, rd_s1_r, wr_s1_r, inc_s1_r, inh_s1_r};
            adr_s1_r <= io.io_address;
            adr_s2_r <= adr_s1_r;
            dat_s1_r <= io.io_data_to_engine;
            dat_s2_r <= dat_s1_r;
        end
    end

    // The buffered word feeds the adder only in the add-to-memory data cycle.
    assign sum = {1'b0, dsr_r} +
        {1'b0, (kind_r == BRK_ADD_MEM && st_r == S_DT_WR) ? fifo_out_data : WORD_ONE};
    assign fifo_pop = (st_r == S_DT_WR) && mem_addr_ack && fifo_out_valid;
    assign busy = (st_r != S_IDLE);
    assign io.device_output_pulse = opulse_r;
    assign io.device_input_pulse = ipulse_r;
    assign io.count_overflow_signal = ovf_r;
    assign io.io_data_to_device = dout_r;
    assign io.break_done = done_r;
    assign latency_over = late_r;

    always_comb begin
        st_nxt = st_r;
        kind_nxt = kind_r;
        dsr_nxt = dsr_r;
        addr_nxt = addr_r;
        inh_nxt = inh_r;
        ovf_nxt = ovf_r;
        opulse_nxt = 1'b0;
        ipulse_nxt = 1'b0;
        done_nxt = 1'b0;
        wait_low_nxt = wait_low_r && req_s2_r;
        dout_nxt = dout_r;
        lat_nxt = lat_r;
        late_nxt = late_r;
        mem_req = 1'b0;
        mem_write = 1'b0;
        mem_rpw = 1'b0;
        mem_addr = dsr_r[ADDR_W-1:0];
        mem_wdata = dsr_r;
        if (st_r != S_IDLE && lat_r != 16'hFFFF) begin
            lat_nxt = lat_r + 16'h0001;
        end
        unique case (st_r)
            S_IDLE: begin
                // A new break is taken only once the last one has fully ended.
                // The synchroniser still shows a finished request for two clocks, so a new
                // break waits until the request line has been seen low.
                if (req_s2_r && !done_r && !wait_low_r) begin
                    lat_nxt = 16'h0000;
                    late_nxt = 1'b0;
                    dsr_nxt = {{(WORD_W-ADDR_W){1'b0}}, adr_s2_r};
                    addr_nxt = adr_s2_r;
                    inh_nxt = inh_s2_r;
                    if (inc_s2_r) begin
                        kind_nxt = BRK_INC_MEM;
                        st_nxt = S_WC_RD;
                    end else if (rd_s2_r && wr_s2_r) begin
                        kind_nxt = BRK_ADD_MEM;
                        st_nxt = S_WC_RD;
                    end else if (wr_s2_r) begin
                        kind_nxt = BRK_MC_IN;
                        st_nxt = S_WC_RD;
                    end else if (rd_s2_r) begin
                        kind_nxt = BRK_MC_OUT;
                        st_nxt = S_WC_RD;
                    end else begin
                        kind_nxt = BRK_SC_OUT;
                        st_nxt = S_DT_RD;
                    end
                end
            end
            S_WC_RD, S_CA_RD: begin
                mem_req = 1'b1;
                mem_rpw = 1'b1;
                if (mem_rd_restart) begin
                    dsr_nxt = mem_rdata;
                    st_nxt = (st_r == S_WC_RD) ? S_WC_WR : S_CA_WR;
                end
            end
            S_WC_WR: begin
                mem_req = 1'b1;
                mem_write = 1'b1;
                mem_addr = addr_r;
                mem_wdata = sum[WORD_W-1:0];
                if (mem_addr_ack) begin
                    if (sum[WORD_W]) begin
                        ovf_nxt = 1'b1;
                    end
                    if (kind_r == BRK_INC_MEM) begin
                        st_nxt = S_IDLE;
                        done_nxt = 1'b1;
                    end else begin
                        addr_nxt = addr_r + ADDR_ONE;
                        dsr_nxt = {{(WORD_W-ADDR_W){1'b0}}, addr_r + ADDR_ONE};
                        st_nxt = S_CA_RD;
                        ipulse_nxt = (kind_r == BRK_MC_IN || kind_r == BRK_ADD_MEM)
                            && fifo_in_ready;
                    end
                end
            end
            S_CA_WR: begin
                mem_req = 1'b1;
                mem_write = 1'b1;
                mem_addr = addr_r;
                mem_wdata = inh_r ? dsr_r : sum[WORD_W-1:0];
                if (mem_addr_ack) begin
                    dsr_nxt = mem_wdata;
                    addr_nxt = mem_wdata[ADDR_W-1:0];
                    st_nxt = (kind_r == BRK_MC_IN) ? S_DT_WR : S_DT_RD;
                end
            end
            S_DT_RD: begin
                // The engine stalls here until memory restarts it.
                mem_req = 1'b1;
                mem_rpw = (kind_r == BRK_ADD_MEM);
                if (mem_rd_restart) begin
                    dsr_nxt = mem_rdata;
                    st_nxt = (kind_r == BRK_ADD_MEM) ? S_DT_WR : S_PULSE;
                end
            end
            S_DT_WR: begin
                mem_req = fifo_out_valid || kind_r == BRK_ADD_MEM;
                // In add to memory the data register holds the memory word here, so the address comes from addr_r.
                mem_addr = addr_r;
                mem_write = 1'b1;
                mem_wdata = (kind_r == BRK_ADD_MEM) ? sum[WORD_W-1:0] : fifo_out_data;
                if (mem_addr_ack && mem_req) begin
                    dsr_nxt = mem_wdata;
                    if (kind_r == BRK_ADD_MEM) begin
                        st_nxt = S_PULSE;
                    end else begin
                        st_nxt = S_IDLE;
                        done_nxt = 1'b1;
                    end
                end
            end
            S_PULSE: begin
                dout_nxt = dsr_r;
                opulse_nxt = 1'b1;
                done_nxt = 1'b1;
                st_nxt = S_IDLE;
                if (kind_r == BRK_SC_OUT && lat_r > 16'(SC_LATENCY_CYC)) begin
                    late_nxt = 1'b1;
                end
            end
            default: st_nxt = S_IDLE;
        endcase
        if (ipulse_r) begin
            ipulse_nxt = 1'b0;
        end
        if (done_nxt) begin
            wait_low_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_r <= S_IDLE;
            kind_r <= BRK_SC_OUT;
            dsr_r <= WORD_ZERO;
            addr_r <= ADDR_ZERO;
            inh_r <= 1'b0;
            ovf_r <= 1'b0;
            opulse_r <= 1'b0;
            ipulse_r <= 1'b0;
            done_r <= 1'b0;
            wait_low_r <= 1'b0;
            dout_r <= WORD_ZERO;
            lat_r <= 16'h0000;
            late_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            kind_r <= kind_nxt;
            dsr_r <= dsr_nxt;
            addr_r <= addr_nxt;
            inh_r <= inh_nxt;
            ovf_r <= ovf_nxt;
            opulse_r <= opulse_nxt;
            ipulse_r <= ipulse_nxt;
            done_r <= done_nxt;
            wait_low_r <= wait_low_nxt;
            dout_r <= dout_nxt;
            lat_r <= lat_nxt;
            late_r <= late_nxt;
        end
    end
endmodule // dch_engine

// ==== hw/dch_if.sv ====
// Interface joining the break engine and a peripheral controller on the I/O bus.
`timescale 1ns/100ps
interface dch_if;
    import dch_pkg::*;
    logic channel_break_request;
    logic read_request_line;
    logic write_request_line;
    logic increment_memory_line;
    logic inhibit_increment_line;
    logic [ADDR_W-1:0] io_address;
    logic [WORD_W-1:0] io_data_to_engine;
    logic [WORD_W-1:0] io_data_to_device;
    logic device_output_pulse;
    logic device_input_pulse;
    logic count_overflow_signal;
    logic break_done;

    modport engine (
        input channel_break_request, read_request_line, write_request_line,
        input increment_memory_line, inhibit_increment_line, io_address, io_data_to_engine,
        output io_data_to_device, device_output_pulse, device_input_pulse,
        output count_overflow_signal, break_done
    );
    modport device (
        output channel_break_request, read_request_line, write_request_line,
        output increment_memory_line, inhibit_increment_line, io_address, io_data_to_engine,
        input io_data_to_device, device_output_pulse, device_input_pulse,
        input count_overflow_signal, break_done
    );
endinterface

// ==== hw/dch_pkg.sv ====
// Shared constants and types for the data channel break engine and its peripheral end.
package dch_pkg;
    localparam int WORD_W = 18;
    localparam int ADDR_W = 15;
    localparam int MCLK_MHZ = 40;
    // Worst case single cycle output latency in nanoseconds.
    localparam int SC_LATENCY_NS = 8500;
    localparam int SC_LATENCY_CYC = (SC_LATENCY_NS * MCLK_MHZ) / 1000;
    localparam int FIFO_DEPTH = 16;
    localparam logic [WORD_W-1:0] WORD_ONE = 18'h00001;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 15'h0001;
    localparam logic [WORD_W-1:0] WORD_ZERO = 18'h00000;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 15'h0000;

    // Break kinds that the peripheral's request lines select.
    typedef enum logic [2:0] {
        BRK_SC_OUT = 3'h0,
        BRK_MC_IN = 3'h1,
        BRK_MC_OUT = 3'h2,
        BRK_ADD_MEM = 3'h3,
        BRK_INC_MEM = 3'h4
    } brk_kind_t;
endpackage

// ==== hw/word_fifo.sv ====
// Parameterised flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module word_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic resetn,
    // Fill side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [PW:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign in_ready = (cnt_r != (PW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
        for (int i = 0; i < DEPTH; i++) begin
            mem_nxt[i] = (push && wp_r == PW'(i)) ? in_data : mem_r[i];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            mem_r <= mem_nxt;
        end
    end
endmodule // word_fifo

// ==== tb/dch_monitor.sv ====
// Concurrent checks on the I/O bus between the break engine and its peripheral end.
`timescale 1ns/100ps
module dch_monitor
    import dch_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic resetn,
    // Bus lines.
    input wire logic channel_break_request,
    input wire logic increment_memory_line,
    input wire logic device_output_pulse,
    input wire logic device_input_pulse,
    input wire logic count_overflow_signal,
    input wire logic break_done
);
    import dch_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    // The output pulse comes late in a break, so the end must follow soon after it.
    sequence out_then_done;
        device_output_pulse ##[0:16] break_done;
    endsequence
    sequence in_once;
        device_input_pulse ##1 !device_input_pulse;
    endsequence
    done_once_a: assert property (break_done |=> !break_done)
        else $error("break done held for more than one cycle");
    done_req_a: assert property (break_done |-> channel_break_request)
        else $error("break done without a pending request");
    out_once_a: assert property (device_output_pulse |=> !device_output_pulse)
        else $error("output pulse longer than one cycle");
    out_done_a: assert property (device_output_pulse |-> out_then_done)
        else $error("no break end after the output pulse");
    in_pulse_a: assert property (device_input_pulse |-> channel_break_request and in_once)
        else $error("input pulse outside a break or too long");
    ovf_sticky_a: assert property (count_overflow_signal |=> count_overflow_signal)
        else $error("overflow dropped before reset");
    ovf_rise_a: assert property ($rose(count_overflow_signal) |-> channel_break_request)
        else $error("overflow raised outside a break");
    inc_only_a: assert property (channel_break_request && increment_memory_line
        |-> !device_output_pulse && !device_input_pulse)
        else $error("data pulse during an increment break");
    req_hold_a: assert property (channel_break_request && !break_done
        |=> channel_break_request)
        else $error("request dropped before break end");
    ovf_quiet_a: assert property (count_overflow_signal && !channel_break_request
        |=> !channel_break_request)
        else $error("request raised after overflow");
endmodule // dch_monitor

// ==== tb/testbench.sv ====
// Self-checking bench: engine and peripheral end joined over the I/O bus.
`timescale 1ns/100ps
module testbench;
    import dch_pkg::*;
    typedef struct {
        brk_kind_t k;
        logic inh;
        logic [ADDR_W-1:0] a;
        logic [WORD_W-1:0] wc, ca, wd, dv;
        int lat;
    } row_t;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic mem_req, mem_write, mem_rpw, busy, latency_over, go;
    logic mem_addr_ack = 1'b0;
    logic mem_rd_restart = 1'b0;
    logic [ADDR_W-1:0] mem_addr;
    logic [WORD_W-1:0] mem_wdata, rdata;
    logic [WORD_W-1:0] mem_rdata = 18'h00000;
    logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic start = 1'b0;
    brk_kind_t kind = BRK_SC_OUT;
    logic inhibit_increment = 1'b0;
    logic [ADDR_W-1:0] address = 15'h0000;
    logic [WORD_W-1:0] wdata = 18'h00000;
    logic rdata_valid, pending, stopped;
    int err_count = 0;
    int n_checks = 0;
    int mem_lat = 0;
    int wait_c = 0;
    int ops = 0;
    int nf = 0;
    int nd = 0;
    int n0 = 0;
    // Memory handshakes per break kind: a read/pause/write costs a restart and an acknowledge.
    int nops [5] = '{1, 5, 5, 6, 2};
    row_t rows [7] = '{
        '{BRK_SC_OUT, 1'b0, 15'h0100, 18'h00000, 18'h00000, 18'h00000, 18'h2A5A5, 0},
        '{BRK_SC_OUT, 1'b0, 15'h0101, 18'h00000, 18'h00000, 18'h00000, 18'h15A5A, 3},
        '{BRK_MC_IN, 1'b0, 15'h0200, 18'h3FFF0, 18'h001FE, 18'h12345, 18'h00000, 1},
        '{BRK_MC_IN, 1'b1, 15'h0210, 18'h00005, 18'h00300, 18'h0ABCD, 18'h00000, 0},
        '{BRK_MC_OUT, 1'b0, 15'h0220, 18'h3FFF8, 18'h00400, 18'h00000, 18'h33333, 2},
        '{BRK_ADD_MEM, 1'b0, 15'h0230, 18'h00010, 18'h00500, 18'h00011, 18'h3FFF0, 1},
        '{BRK_INC_MEM, 1'b0, 15'h0240, 18'h00007, 18'h00700, 18'h00000, 18'h00000, 0}
    };

    always #12.5 mclk = ~mclk;

    dch_if bus ();
    dch_engine #(.FDEPTH(FIFO_DEPTH)) dch_engine_inst (.mclk(mclk), .resetn(resetn), .io(bus),
        .mem_req(mem_req), .mem_write(mem_write), .mem_rpw(mem_rpw), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_addr_ack(mem_addr_ack), .mem_rd_restart(mem_rd_restart),
        .mem_rdata(mem_rdata), .busy(busy), .latency_over(latency_over));
    dch_device dch_device_inst (.mclk(mclk), .resetn(resetn), .io(bus), .start(start),
        .kind(kind), .inhibit_increment(inhibit_increment), .address(address), .wdata(wdata),
        .rdata(rdata), .rdata_valid(rdata_valid), .pending(pending), .stopped(stopped));
    dch_monitor dch_monitor_inst (.mclk(mclk), .resetn(resetn),
        .channel_break_request(bus.channel_break_request),
        .increment_memory_line(bus.increment_memory_line),
        .device_output_pulse(bus.device_output_pulse),
        .device_input_pulse(bus.device_input_pulse),
        .count_overflow_signal(bus.count_overflow_signal), .break_done(bus.break_done));

    // Memory answers after mem_lat cycles; read data is scrambled outside a restart.
    always @(posedge mclk) begin
        go = mem_req === 1'b1 && !mem_addr_ack && !mem_rd_restart && wait_c >= mem_lat;
        mem_addr_ack <= go && mem_write;
        mem_rd_restart <= go && !mem_write;
        mem_rdata <= (go && !mem_write) ? mem[mem_addr] : ~mem_rdata;
        if (go && mem_write) mem[mem_addr] <= mem_wdata;
        wait_c <= go ? 0 : wait_c + (mem_req === 1'b1);
        ops <= ops + go;
    end

    // Input pulses seen on the bus, one for each break that carries a word in.
    always @(posedge mclk) nd <= nd + (bus.device_input_pulse === 1'b1);

    task automatic chk(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic do_row(input row_t r);
        logic [WORD_W-1:0] got, ca1;
        logic [ADDR_W-1:0] a1, t;
        int n;
        int o0;
        ca1 = r.inh ? r.ca : r.ca + WORD_ONE;
        a1 = r.a + ADDR_ONE;
        t = ca1[ADDR_W-1:0];
        got = WORD_ZERO;
        n = 0;
        mem[r.a] = (r.k == BRK_SC_OUT) ? r.dv : r.wc;
        mem[a1] = r.ca;
        if (r.k != BRK_SC_OUT) mem[t] = r.dv;
        mem_lat = r.lat;
        o0 = ops;
        kind <= r.k;
        inhibit_increment <= r.inh;
        address <= r.a;
        wdata <= r.wd;
        start <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
        do begin
            @(posedge mclk);
            if (rdata_valid === 1'b1) got = rdata;
            n++;
        end while (bus.break_done !== 1'b1 && n < 600);
        if (n >= 600) begin
            err_count++;
            summarize();
        end
        repeat (2) begin
            @(posedge mclk);
            if (rdata_valid === 1'b1) got = rdata;
        end
        chk(WORD_W'(ops - o0), WORD_W'(nops[r.k]));
        if (r.k == BRK_SC_OUT) begin
            chk(got, r.dv);
            chk(n <= SC_LATENCY_CYC, 1'b1);
        end else begin
            chk(mem[r.a], r.wc + WORD_ONE);
            chk(mem[a1], (r.k == BRK_INC_MEM) ? r.ca : ca1);
        end
        if (r.k == BRK_MC_IN) chk(mem[t], r.wd);
        if (r.k == BRK_MC_OUT) chk(got, r.dv);
        if (r.k == BRK_INC_MEM) chk(mem[t], r.dv);
        if (r.k == BRK_ADD_MEM) begin
            chk(mem[t], r.dv + r.wd);
            chk(got, r.dv + r.wd);
        end
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        foreach (rows[i]) do_row(rows[i]);
        // A full word count wraps to zero; the break still completes.
        do_row('{BRK_MC_IN, 1'b0, 15'h0250, 18'h3FFFF, 18'h00600, 18'h00777, 18'h00000, 1});
        chk(bus.count_overflow_signal, 1'b1);
        chk(stopped, 1'b1);
        start <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
        repeat (8) @(posedge mclk);
        chk(bus.channel_break_request, 1'b0);
        chk(pending, 1'b0);
        resetn <= 1'b0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        chk(bus.count_overflow_signal, 1'b0);
        chk(stopped, 1'b0);
        @(posedge mclk);
        do_row(rows[1]);
        chk(latency_over, 1'b0);
        chk(busy, 1'b0);
        // Three input breaks and one add-to-memory break have each taken one word so far.
        chk(WORD_W'(nd), WORD_W'(4));
        // More input breaks than the buffer holds: each must capture and retire one word.
        nf = nd;
        for (int i = 0; i < FIFO_DEPTH + 2; i++) begin
            n0 = nd;
            do_row('{BRK_MC_IN, 1'b0, 15'h0300, WORD_W'(i), 18'h00400, WORD_W'(i * 5 + 1),
                WORD_ZERO, 0});
            chk(WORD_W'(nd - n0), WORD_W'(1));
        end
        chk(WORD_W'(nd - nf), WORD_W'(FIFO_DEPTH + 2));
        summarize();
    end
endmodule // testbench
